/* File: design/pin_fall_sync.sv */
// Three-stage pin synchroniser with a one-cycle falling-edge pulse
`timescale 1ns/1ns
module pin_fall_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin and event
   input wire logic pin,
   output logic fall
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Level moves only when stages two and three agree, which filters a one-cycle glitch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_reg <= 1'b1;
         fall <= 1'b0;
      end else begin
         fall <= 1'b0;
         if (s2_reg == s3_reg && s3_reg != level_reg) begin
            level_reg <= s3_reg;
            fall <= ~s3_reg;
         end
      end
   end
endmodule : pin_fall_sync

/* File: design/tick_divider.sv */
// Free-running divider giving a one-cycle enable every DIV clocks
`timescale 1ns/1ns
module tick_divider #(
   parameter int DIV = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Enable pulse
   output logic tick
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   localparam logic [CW-1:0] STEP = CW'(1);

   logic [CW-1:0] cnt_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt_reg == LAST);
         cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + STEP;
      end
   end
endmodule : tick_divider

/* File: design/timer2_capture_reload.sv */
// Sixteen-bit timer/counter with capture, auto-reload and baud generation, APB slave
`timescale 1ns/1ns
module timer2_capture_reload (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // APB slave
   input timer2_pkg::apb_req_t APB_REQ,
   output timer2_pkg::apb_rsp_t APB_RSP,
   // External pins
   input wire logic COUNT_PIN,
   input wire logic TRIGGER_PIN,
   // Interrupt and baud outputs
   output logic TIMER_IRQ,
   output logic TX_BAUD_TICK,
   output logic RX_BAUD_TICK
);
   import timer2_pkg::*;

   // ==========================================================
   // Declarations
   ctrl_t ctrl_reg;
   ctrl_t ctrl_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic [15:0] reload_reg;
   logic [15:0] reload_next;
   logic irq_en_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic tx_tick_reg;
   logic rx_tick_reg;
   mode_t mode;
   logic timer_pulse;
   logic baud_pulse;
   logic count_fall;
   logic trig_fall;
   logic step;
   logic wrap;
   logic trig_hit;
   logic seventeenth;
   logic setup;
   logic access;
   logic mapped;
   logic wr_ctrl;
   logic wr_count;
   logic wr_reload;
   logic wr_irq;
   logic [DATA_W-1:0] rd_mux;

   // ==========================================================
   // Pulse sources
   // Dividers run free from reset, so the first count after a start lands anywhere in a period
   tick_divider #(.DIV(TIMER_DIV)) u_timer_div (
      .clk(MCLK),
      .rst_n(RESET_N),
      .tick(timer_pulse)
   );

   tick_divider #(.DIV(BAUD_DIV)) u_baud_div (
      .clk(MCLK),
      .rst_n(RESET_N),
      .tick(baud_pulse)
   );

   pin_fall_sync u_count_sync (
      .clk(MCLK),
      .rst_n(RESET_N),
      .pin(COUNT_PIN),
      .fall(count_fall)
   );

   pin_fall_sync u_trig_sync (
      .clk(MCLK),
      .rst_n(RESET_N),
      .pin(TRIGGER_PIN),
      .fall(trig_fall)
   );

   // ==========================================================
   // Mode decode
   // Baud selects outrank the capture/reload select; run control clear stops counting, wraps and triggers
   always_comb begin
      if (!ctrl_reg.run_control) begin
         mode = MODE_OFF;
      end else if (ctrl_reg.receive_baud_select || ctrl_reg.transmit_baud_select) begin
         mode = MODE_BAUD;
      end else if (ctrl_reg.capture_reload_select) begin
         mode = MODE_CAPT;
      end else begin
         mode = MODE_AUTO;
      end
   end

   // ==========================================================
   // Count enable: pin edges as a counter, divided core clock as a timer
   always_comb begin
      if (mode == MODE_OFF) begin
         step = 1'b0;
      end else if (ctrl_reg.counter_timer_select) begin
         step = count_fall;
      end else if (mode == MODE_BAUD) begin
         step = baud_pulse;
      end else begin
         step = timer_pulse;
      end
   end

   // Wrap is judged on a step, so a stopped counter resting at ffff never wraps
   assign wrap = step && (count_reg == COUNT_MAX);
   // A trigger while stopped or disabled is dropped, not held for later
   assign trig_hit = trig_fall && ctrl_reg.external_trigger_enable && (mode != MODE_OFF);
   // Flag used as the seventeenth bit only in auto-reload with the trigger disabled
   assign seventeenth = (mode == MODE_AUTO) && !ctrl_reg.external_trigger_enable;

   // ==========================================================
   // APB decode: zero wait states, so a request completes in its first access cycle
   assign setup = APB_REQ.psel && !APB_REQ.penable;
   assign access = APB_REQ.psel && APB_REQ.penable;
   assign mapped = (APB_REQ.paddr == OFS_CTRL) || (APB_REQ.paddr == OFS_COUNT) ||
                   (APB_REQ.paddr == OFS_RELOAD) || (APB_REQ.paddr == OFS_IRQ_EN);
   assign wr_ctrl = access && APB_REQ.pwrite && (APB_REQ.paddr == OFS_CTRL);
   assign wr_count = access && APB_REQ.pwrite && (APB_REQ.paddr == OFS_COUNT);
   assign wr_reload = access && APB_REQ.pwrite && (APB_REQ.paddr == OFS_RELOAD);
   assign wr_irq = access && APB_REQ.pwrite && (APB_REQ.paddr == OFS_IRQ_EN);

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [DATA_W-1:0] wd,
                                           input logic [STRB_W-1:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[COUNT_LOW_LSB +: 8] = wd[7:0];
      end
      if (strb[1]) begin
         res[COUNT_HIGH_LSB +: 8] = wd[15:8];
      end
      return res;
   endfunction : merge16

   // ==========================================================
   // Count register
   always_comb begin
      count_next = count_reg;
      if (wrap) begin
         case (mode)
            MODE_AUTO: count_next = reload_reg;
            MODE_BAUD: count_next = reload_reg;
            MODE_CAPT: count_next = '0;
            default: count_next = count_reg;
         endcase
      end else if (step) begin
         count_next = count_reg + COUNT_ONE;
      end
      // Trigger reload only in auto-reload; in baud mode the edge must not reload
      if (trig_hit && mode == MODE_AUTO) begin
         count_next = reload_reg;
      end
      // Software write wins; the timer should be stopped before writing it
      if (wr_count) begin
         count_next = merge16(count_reg, APB_REQ.pwdata, APB_REQ.pstrb);
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         count_reg <= COUNT_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   // ==========================================================
   // Reload/capture register: a capture wins over a software write in the same cycle
   always_comb begin
      reload_next = reload_reg;
      if (wr_reload) begin
         reload_next = merge16(reload_reg, APB_REQ.pwdata, APB_REQ.pstrb);
      end
      if (trig_hit && mode == MODE_CAPT) begin
         reload_next = count_reg;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         reload_reg <= RELOAD_RESET;
      end else begin
         reload_reg <= reload_next;
      end
   end

   // ==========================================================
   // Control register and flags: hardware set or toggle wins over a software write
   // Software may also set a flag by writing one, which lets a handler be exercised
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl && APB_REQ.pstrb[0]) begin
         ctrl_next = ctrl_t'(APB_REQ.pwdata[7:0]);
      end
      if (wrap && (mode == MODE_AUTO || mode == MODE_CAPT)) begin
         ctrl_next.overflow_flag = 1'b1;
      end
      if (wrap && seventeenth) begin
         ctrl_next.external_trigger_flag = ~ctrl_reg.external_trigger_flag;
      end
      if (trig_hit) begin
         ctrl_next.external_trigger_flag = 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_reg <= ctrl_t'(CTRL_RESET);
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         irq_en_reg <= IRQ_EN_RESET;
      end else if (wr_irq && APB_REQ.pstrb[0]) begin
         irq_en_reg <= APB_REQ.pwdata[BIT_TIMER_IRQ_ENABLE];
      end
   end

   // ==========================================================
   // Shared interrupt: flags stay set until software clears them, save the seventeenth-bit toggle of the external flag
   // Registered so the request stays clean while flags and mode change together
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TIMER_IRQ <= 1'b0;
      end else begin
         TIMER_IRQ <= irq_en_reg && (ctrl_reg.overflow_flag ||
                      (ctrl_reg.external_trigger_flag && !seventeenth));
      end
   end

   // ==========================================================
   // Baud ticks: one pulse per rollover toward the serial port
   // Each direction follows its own select, so one side may take its rate elsewhere
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tx_tick_reg <= 1'b0;
         rx_tick_reg <= 1'b0;
      end else begin
         tx_tick_reg <= wrap && (mode == MODE_BAUD) && ctrl_reg.transmit_baud_select;
         rx_tick_reg <= wrap && (mode == MODE_BAUD) && ctrl_reg.receive_baud_select;
      end
   end

   assign TX_BAUD_TICK = tx_tick_reg;
   assign RX_BAUD_TICK = rx_tick_reg;

   // ==========================================================
   // Read path: data captured in the setup cycle, held through the access cycle
   // A running count therefore reads as its value one cycle before the access
   always_comb begin
      rd_mux = '0;
      case (APB_REQ.paddr)
         OFS_CTRL: rd_mux[7:0] = ctrl_reg;
         OFS_COUNT: rd_mux[15:0] = count_reg;
         OFS_RELOAD: rd_mux[15:0] = reload_reg;
         OFS_IRQ_EN: rd_mux[BIT_TIMER_IRQ_ENABLE] = irq_en_reg;
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_reg <= '0;
      end else if (setup) begin
         rdata_reg <= APB_REQ.pwrite ? '0 : rd_mux;
      end
   end

   always_comb begin
      APB_RSP.prdata = rdata_reg;
      APB_RSP.pready = 1'b1;
      APB_RSP.pslverr = access && !mapped;
   end

endmodule : timer2_capture_reload

/* File: design/timer2_pkg.sv */
// Shared constants, register map and carrier types of the capture/reload timer
package timer2_pkg;

   // ==========================================================
   // Bus widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   // ==========================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_RELOAD = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h00c;

   // ==========================================================
   // Control, interrupt enable and count byte field positions
   localparam int BIT_CAPTURE_RELOAD_SELECT = 0;
   localparam int BIT_COUNTER_TIMER_SELECT = 1;
   localparam int BIT_RUN_CONTROL = 2;
   localparam int BIT_EXTERNAL_TRIGGER_ENABLE = 3;
   localparam int BIT_TRANSMIT_BAUD_SELECT = 4;
   localparam int BIT_RECEIVE_BAUD_SELECT = 5;
   localparam int BIT_EXTERNAL_TRIGGER_FLAG = 6;
   localparam int BIT_OVERFLOW_FLAG = 7;
   localparam int BIT_TIMER_IRQ_ENABLE = 0;
   localparam int COUNT_LOW_LSB = 0;
   localparam int COUNT_HIGH_LSB = 8;

   // ==========================================================
   // Reset values and count limits
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic IRQ_EN_RESET = 1'b0;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ONE = 16'h0001;

   // ==========================================================
   // Timing: core clock cycles per count in timer and baud operation
   localparam int TIMER_DIV = 12;
   localparam int BAUD_DIV = 2;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {MODE_OFF, MODE_AUTO, MODE_CAPT, MODE_BAUD} mode_t;

   typedef struct packed {
      logic overflow_flag;
      logic external_trigger_flag;
      logic receive_baud_select;
      logic transmit_baud_select;
      logic external_trigger_enable;
      logic run_control;
      logic counter_timer_select;
      logic capture_reload_select;
   } ctrl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
      logic [STRB_W-1:0] pstrb;
   } apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

endpackage : timer2_pkg

/* File: sim/pin_model.sv */
// Far-side model of the external count and trigger pins
`timescale 1ns/1ns
module pin_model (
   // Clock
   input wire logic clk,
   // Pins, idle high as on a pulled-up port
   output logic count_pin,
   output logic trigger_pin
);
   initial begin
      count_pin = 1'b1;
      trigger_pin = 1'b1;
   end
   // Three-clock phases clear the two-clock minimum; the tail covers sync and update
   task automatic pulse(input logic trig);
      @(posedge clk);
      if (trig) begin
         trigger_pin <= 1'b0;
      end else begin
         count_pin <= 1'b0;
      end
      repeat (3) @(posedge clk);
      trigger_pin <= 1'b1;
      count_pin <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : pulse
endmodule : pin_model

/* File: sim/tb.sv */
// Register-level tests of the capture/reload timer
`timescale 1ns/1ns
module tb;
   import timer2_pkg::*;
   logic mclk, rst_n, irq, tx_tick, rx_tick, count_pin, trig_pin, rerr;
   logic [31:0] rdat;
   apb_req_t req;
   apb_rsp_t rsp;
   int n_fail, total_checks, cycles, tx_n, rx_n, tx0, rx0;

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   timer2_capture_reload DUT (.MCLK(mclk), .RESET_N(rst_n), .APB_REQ(req), .APB_RSP(rsp),
      .COUNT_PIN(count_pin), .TRIGGER_PIN(trig_pin), .TIMER_IRQ(irq),
      .TX_BAUD_TICK(tx_tick), .RX_BAUD_TICK(rx_tick));
   pin_model u_pins (.clk(mclk), .count_pin(count_pin), .trigger_pin(trig_pin));

   // ==========================================================
   // Tick counters and hang guard
   always @(posedge mclk) begin
      if (tx_tick === 1'b1) tx_n++;
      if (rx_tick === 1'b1) rx_n++;
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         final_report();
      end
   end

   // ==========================================================
   // Bus tasks and comparisons
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge mclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
      @(posedge mclk);
      req.penable <= 1'b1;
      do @(posedge mclk); while (rsp.pready !== 1'b1);
      rdat = rsp.prdata;
      rerr = rsp.pslverr;
      req <= '0;
   endtask : apb
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk32
   task automatic chk1(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk1
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      apb(1'b1, a, d, s);
   endtask : wr
   task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp,
                     input logic err = 1'b0);
      apb(1'b0, a, 32'h0, 4'h0);
      chk32(what, exp, rdat);
      chk1({what, "_err"}, err, rerr);
   endtask : rd
   task automatic irq_is(input logic exp);
      repeat (3) @(posedge mclk);
      chk1("irq", exp, irq);
   endtask : irq_is
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // Test sequence
   initial begin
      rst_n = 1'b0;
      req = '0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      rd("ctrl", OFS_CTRL, 32'h0);
      rd("count", OFS_COUNT, 32'h0);
      rd("reload", OFS_RELOAD, 32'h0);
      rd("irq_en", OFS_IRQ_EN, 32'h0);
      wr(12'h010, 32'hffffffff);
      rd("hole", 12'h010, 32'h0, 1'b1);
      // Byte lanes: low and high count bytes apart, unused lanes and empty strobes ignored
      wr(OFS_COUNT, 32'h0000abcd, 4'h1);
      wr(OFS_COUNT, 32'h00001200, 4'h2);
      rd("count_lanes", OFS_COUNT, 32'h12cd);
      wr(OFS_RELOAD, 32'hffffffff, 4'hc);
      rd("reload_lanes", OFS_RELOAD, 32'h0);
      wr(OFS_CTRL, 32'h04, 4'h0);
      wr(OFS_IRQ_EN, 32'h1, 4'he);
      rd("ctrl_lanes", OFS_CTRL, 32'h0);
      rd("irq_en_lanes", OFS_IRQ_EN, 32'h0);
      $display("test reset_map done");
      // Stopped counter ignores the pin, then counts and captures
      wr(OFS_CTRL, 32'h02);
      wr(OFS_COUNT, 32'h1234);
      u_pins.pulse(1'b0);
      rd("count_stopped", OFS_COUNT, 32'h1234);
      wr(OFS_CTRL, 32'h0f);
      repeat (3) u_pins.pulse(1'b0);
      rd("count_pin", OFS_COUNT, 32'h1237);
      u_pins.pulse(1'b1);
      rd("capture", OFS_RELOAD, 32'h1237);
      rd("ctrl_ext", OFS_CTRL, 32'h4f);
      u_pins.pulse(1'b0);
      rd("count_on", OFS_COUNT, 32'h1238);
      wr(OFS_IRQ_EN, 32'h1);
      irq_is(1'b1);
      wr(OFS_CTRL, 32'h0b);
      irq_is(1'b0);
      $display("test capture_counter done");
      // Timer operation overflows while masked, then unmasked
      wr(OFS_IRQ_EN, 32'h0);
      wr(OFS_COUNT, 32'hfff0);
      wr(OFS_CTRL, 32'h05);
      irq_is(1'b0);
      repeat (250) @(posedge mclk);
      chk1("irq_masked", 1'b0, irq);
      rd("ctrl_ovf", OFS_CTRL, 32'h85);
      wr(OFS_IRQ_EN, 32'h1);
      irq_is(1'b1);
      wr(OFS_CTRL, 32'h00);
      irq_is(1'b0);
      $display("test capture_timer done");
      // Auto-reload on wrap, then on trigger
      wr(OFS_RELOAD, 32'h5555);
      wr(OFS_COUNT, 32'hffff);
      wr(OFS_CTRL, 32'h06);
      u_pins.pulse(1'b0);
      rd("count_reload", OFS_COUNT, 32'h5555);
      rd("ctrl_wrap", OFS_CTRL, 32'hc6);
      chk1("irq_ovf", 1'b1, irq);
      wr(OFS_CTRL, 32'h46);
      irq_is(1'b0);
      wr(OFS_COUNT, 32'h0100);
      wr(OFS_CTRL, 32'h0e);
      u_pins.pulse(1'b1);
      rd("count_trig", OFS_COUNT, 32'h5555);
      rd("ctrl_trig", OFS_CTRL, 32'h4e);
      chk1("irq_ext", 1'b1, irq);
      $display("test auto_reload done");
      // Baud generation from the count pin, both directions
      wr(OFS_CTRL, 32'h00);
      wr(OFS_RELOAD, 32'hfffe);
      wr(OFS_COUNT, 32'hfffe);
      wr(OFS_CTRL, 32'h3e);
      tx0 = tx_n;
      rx0 = rx_n;
      repeat (2) u_pins.pulse(1'b0);
      rd("count_baud", OFS_COUNT, 32'hfffe);
      chk32("tx_ticks", 32'd1, 32'(tx_n - tx0));
      chk32("rx_ticks", 32'd1, 32'(rx_n - rx0));
      chk1("irq_baud", 1'b0, irq);
      u_pins.pulse(1'b1);
      rd("count_noreload", OFS_COUNT, 32'hfffe);
      rd("ctrl_baud", OFS_CTRL, 32'h7e);
      chk1("irq_baud_ext", 1'b1, irq);
      $display("test baud done");
      // Transmit-only baud, then auto-reload, both from the divided core clock
      wr(OFS_CTRL, 32'h00);
      wr(OFS_COUNT, 32'hfff0);
      wr(OFS_CTRL, 32'h14);
      tx0 = tx_n;
      rx0 = rx_n;
      repeat (200) @(posedge mclk);
      rd("ctrl_baud_tmr", OFS_CTRL, 32'h14);
      chk1("irq_baud_tmr", 1'b0, irq);
      wr(OFS_CTRL, 32'h00);
      chk1("tx_timer", 1'b1, (tx_n - tx0) > 10);
      chk32("rx_timer", 32'd0, 32'(rx_n - rx0));
      wr(OFS_RELOAD, 32'h1234);
      wr(OFS_COUNT, 32'hfffe);
      wr(OFS_CTRL, 32'h04);
      repeat (40) @(posedge mclk);
      apb(1'b0, OFS_COUNT, 32'h0, 4'h0);
      chk32("count_auto_tmr", 32'h1234, rdat & 32'hfffffffc);
      rd("ctrl_auto_tmr", OFS_CTRL, 32'hc4);
      chk1("irq_auto_tmr", 1'b1, irq);
      $display("test timer_modes done");
      // Reset in mid-run clears state and the request
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd("ctrl_rst", OFS_CTRL, 32'h0);
      rd("count_rst", OFS_COUNT, 32'h0);
      chk1("irq_rst", 1'b0, irq);
      $display("test mid_reset done");
      final_report();
   end
endmodule : tb

/* File: sim/timer2_props.sv */
// Port-level assertions of the capture/reload timer
`timescale 1ns/1ns
module timer2_props (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // Bus
   input timer2_pkg::apb_req_t APB_REQ,
   input timer2_pkg::apb_rsp_t APB_RSP,
   // Pins and outputs
   input wire logic COUNT_PIN,
   input wire logic TRIGGER_PIN,
   input wire logic TIMER_IRQ,
   input wire logic TX_BAUD_TICK,
   input wire logic RX_BAUD_TICK
);
   import timer2_pkg::*;
   logic acc, wr_lo, hole, wr_cfg, en_reg, tx_reg, rx_reg;
   assign acc = APB_REQ.psel && APB_REQ.penable;
   assign wr_lo = acc && APB_REQ.pwrite && APB_REQ.pstrb[0];
   assign hole = !(APB_REQ.paddr inside {OFS_CTRL, OFS_COUNT, OFS_RELOAD, OFS_IRQ_EN});
   assign wr_cfg = wr_lo && (APB_REQ.paddr == OFS_CTRL || APB_REQ.paddr == OFS_IRQ_EN);
   // ==========================================================
   // Shadows of the enable and baud selects, tracked from bus writes
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) en_reg <= 1'b0;
      else if (wr_lo && APB_REQ.paddr == OFS_IRQ_EN) en_reg <= APB_REQ.pwdata[0];
   end
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tx_reg <= 1'b0;
         rx_reg <= 1'b0;
      end else if (wr_lo && APB_REQ.paddr == OFS_CTRL) begin
         tx_reg <= APB_REQ.pwdata[BIT_TRANSMIT_BAUD_SELECT];
         rx_reg <= APB_REQ.pwdata[BIT_RECEIVE_BAUD_SELECT];
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   // Only software can lower a raised request, so no write means it stays
   sequence s_irq_quiet;
      TIMER_IRQ && !$past(wr_cfg);
   endsequence
   chk_ready_high: assert property (APB_REQ.psel |-> APB_RSP.pready)
      else $error("pready low during a transfer");
   chk_err_hole: assert property (acc |-> APB_RSP.pslverr == hole)
      else $error("pslverr does not match the address map");
   chk_hole_zero: assert property (acc && hole && !APB_REQ.pwrite |-> APB_RSP.prdata == '0)
      else $error("unmapped read returned data");
   chk_irq_masked: assert property (!en_reg && !$past(en_reg) |-> !TIMER_IRQ)
      else $error("interrupt raised while disabled");
   chk_irq_stands: assert property (s_irq_quiet |=> TIMER_IRQ)
      else $error("interrupt dropped without a software write");
   chk_tx_mode: assert property (TX_BAUD_TICK |-> $past(tx_reg))
      else $error("transmit tick outside transmit baud mode");
   chk_rx_mode: assert property (RX_BAUD_TICK |-> $past(rx_reg))
      else $error("receive tick outside receive baud mode");
   chk_tick_pulse: assert property (TX_BAUD_TICK |=> !TX_BAUD_TICK)
      else $error("transmit tick longer than one cycle");
   chk_baud_pair: assert property (TX_BAUD_TICK && $past(rx_reg) |-> RX_BAUD_TICK)
      else $error("receive tick missing beside transmit tick");
endmodule : timer2_props

bind timer2_capture_reload timer2_props u_props (.MCLK(MCLK), .RESET_N(RESET_N),
   .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .COUNT_PIN(COUNT_PIN), .TRIGGER_PIN(TRIGGER_PIN),
   .TIMER_IRQ(TIMER_IRQ), .TX_BAUD_TICK(TX_BAUD_TICK), .RX_BAUD_TICK(RX_BAUD_TICK));
